/* hw/fifo_side_params.svh */
// Offsets, field positions, reset values and counts of the FIFO sideband
`ifndef FIFO_SIDE_PARAMS_SVH
`define FIFO_SIDE_PARAMS_SVH

`define DATA_W            8
`define WORD_W            13
`define DEPTH             16
`define PTR_W             4
`define CNT_W             5
`define ADDR_W            8
`define INJ_BIT_A         3
`define INJ_BIT_B         5
`define SETTLE_CYCLES     2'h3

`define ADDR_CTRL         8'h00
`define ADDR_TH_SINGLE    8'h04
`define ADDR_TH_ASSERT    8'h08
`define ADDR_TH_NEGATE    8'h0c
`define ADDR_STATUS       8'h10
`define ADDR_IRQ_STATUS   8'h14
`define ADDR_IRQ_MASK     8'h18

`define CTRL_RST          6'h04
`define TH_SINGLE_RST     5'h02
`define TH_ASSERT_RST     5'h02
`define TH_NEGATE_RST     5'h04
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`define IRQ_W             5
`define IRQ_SBIT          0
`define IRQ_DBIT          1
`define IRQ_UNDER         2
`define IRQ_OVER          3
`define IRQ_LOW           4

`endif

/* hw/fifo_side_pkg.sv */
// Types shared by the FIFO sideband modules
`include "fifo_side_params.svh"
package fifo_side_pkg;

  typedef struct packed {
    logic sleep;
    logic inject_double;
    logic inject_single;
    logic ecc_en;
    logic split_thresh;
    logic fifo_reset;
  } ctrl_t;

  typedef struct packed {
    logic                awvalid;
    logic [`ADDR_W-1:0]  awaddr;
    logic                wvalid;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bready;
    logic                arvalid;
    logic [`ADDR_W-1:0]  araddr;
    logic                rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef enum logic [1:0] {P_HOLD, P_SETTLE, P_RUN} phase_t;

  typedef struct packed {
    logic                awh;
    logic [`ADDR_W-1:0]  awaddr;
    logic                wh;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    axil_rsp_t           rsp;
    ctrl_t               ctrl;
    logic [`CNT_W-1:0]   th_single;
    logic [`CNT_W-1:0]   th_assert;
    logic [`CNT_W-1:0]   th_negate;
    logic [`CNT_W-1:0]   th_as;
    logic [`CNT_W-1:0]   th_ng;
    logic [`IRQ_W-1:0]   irq_st;
    logic [`IRQ_W-1:0]   irq_mask;
    logic                irq;
    phase_t              phase;
    logic [1:0]          settle;
    logic [`PTR_W-1:0]   wptr;
    logic [`PTR_W-1:0]   rptr;
    logic [`CNT_W-1:0]   count;
    logic [`DATA_W-1:0]  dout;
    logic                dvalid;
    logic                sbit;
    logic                dbit;
    logic                underflow;
    logic                overflow;
    logic                full;
    logic                empty;
    logic                low;
    logic                busy;
  } state_t;

endpackage : fifo_side_pkg

/* hw/secded_codec.sv */
// Hamming SECDED encoder with error injection, and matching decoder
`timescale 1ns/1ps
`include "fifo_side_params.svh"
module secded_codec (
  // Encode side
  input  wire logic [`DATA_W-1:0] enc_data,
  input  wire logic               ecc_en,
  input  wire logic               inj_single,
  input  wire logic               inj_double,
  output      logic [`WORD_W-1:0] enc_word,
  output      logic [`WORD_W-1:0] enc_clean,
  // Decode side
  input  wire logic [`WORD_W-1:0] dec_word,
  output      logic [`DATA_W-1:0] dec_data,
  output      logic               dec_single,
  output      logic               dec_double
);

  // Positions 1..12 carry a Hamming code, bit 0 the overall parity
  function automatic logic [`WORD_W-1:0] encode(input logic [`DATA_W-1:0] d);
    logic [`WORD_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int i = 1; i < `WORD_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[j];
        j++;
      end
    end
    for (int k = 0; k < 4; k++) begin
      for (int i = 1; i < `WORD_W; i++) begin
        if (i[k] && i != (1 << k)) c[1 << k] = c[1 << k] ^ c[i];
      end
    end
    c[0] = ^c[`WORD_W-1:1];
    return c;
  endfunction : encode

  function automatic logic [`DATA_W-1:0] extract(input logic [`WORD_W-1:0] c);
    logic [`DATA_W-1:0] d;
    int j;
    d = '0;
    j = 0;
    for (int i = 1; i < `WORD_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = c[i];
        j++;
      end
    end
    return d;
  endfunction : extract

  logic [`WORD_W-1:0] fixed;
  logic [3:0]         syn;
  logic               ov;

  always_comb begin
    enc_clean = encode(enc_data);
    enc_word  = enc_clean;
    if (ecc_en && (inj_single || inj_double)) begin
      enc_word[`INJ_BIT_A] = ~enc_clean[`INJ_BIT_A];
    end
    if (ecc_en && inj_double) begin
      enc_word[`INJ_BIT_B] = ~enc_clean[`INJ_BIT_B];
    end
  end

  always_comb begin
    syn = 4'h0;
    for (int i = 1; i < `WORD_W; i++) begin
      if (dec_word[i]) syn = syn ^ i[3:0];
    end
    ov         = ^dec_word;
    fixed      = dec_word;
    dec_single = 1'b0;
    dec_double = 1'b0;
    if (ecc_en && ov && syn < 4'(`WORD_W)) begin
      fixed[syn] = ~dec_word[syn];
      dec_single = 1'b1;
    end else if (ecc_en && (syn != 4'h0 || ov)) begin
      dec_double = 1'b1;
    end
    dec_data = extract(fixed);
  end

endmodule : secded_codec

/* hw/word_store.sv */
// Codeword storage array: one write port, one combinational read port
`timescale 1ns/1ps
`include "fifo_side_params.svh"
module word_store (
  // Clock
  input  wire logic               aclk,
  // Write port
  input  wire logic               we,
  input  wire logic [`PTR_W-1:0]  waddr,
  input  wire logic [`WORD_W-1:0] wword,
  // Read port
  input  wire logic [`PTR_W-1:0]  raddr,
  output      logic [`WORD_W-1:0] rword
);

  logic [`WORD_W-1:0] mem [`DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wword;
    end
  end

  assign rword = mem[raddr];

endmodule : word_store

/* hw/fifo_side.sv */
// Single-clock ECC FIFO with low watermark, reset-busy and AXI4-Lite control
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fifo_side_params.svh"
module fifo_side (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Register bus
  input  wire fifo_side_pkg::axil_req_t s_axi_req,
  output      fifo_side_pkg::axil_rsp_t s_axi_rsp,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [`DATA_W-1:0]       din,
  output      logic                     full,
  output      logic                     overflow,
  output      logic                     wr_rst_busy,
  // Read side
  input  wire logic                     rd_en,
  output      logic [`DATA_W-1:0]       dout,
  output      logic                     dout_valid,
  output      logic                     sbit_err,
  output      logic                     dbit_err,
  output      logic                     underflow,
  output      logic                     empty,
  output      logic                     prog_empty,
  output      logic                     rd_rst_busy,
  // Interrupt
  output      logic                     irq
);
  import fifo_side_pkg::*;

  state_t             s_q;
  state_t             s_d;
  logic [`WORD_W-1:0] enc_word;
  logic [`WORD_W-1:0] enc_clean;
  logic [`WORD_W-1:0] rd_word;
  logic [`DATA_W-1:0] dec_data;
  logic               dec_single;
  logic               dec_double;
  logic               wr_ok;
  logic               rd_ok;
  logic               run;
  logic               wr_go;
  logic [`IRQ_W-1:0]  irq_clr;
  logic [`IRQ_W-1:0]  irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  function automatic logic reg_known(input logic [`ADDR_W-1:0] a);
    return a == `ADDR_CTRL || a == `ADDR_TH_SINGLE || a == `ADDR_TH_ASSERT ||
           a == `ADDR_TH_NEGATE || a == `ADDR_STATUS ||
           a == `ADDR_IRQ_STATUS || a == `ADDR_IRQ_MASK;
  endfunction : reg_known

  function automatic logic [31:0] read_mux(input logic [`ADDR_W-1:0] a,
                                           input state_t st);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `ADDR_CTRL:       v[5:0] = st.ctrl;
      `ADDR_TH_SINGLE:  v[`CNT_W-1:0] = st.th_single;
      `ADDR_TH_ASSERT:  v[`CNT_W-1:0] = st.th_assert;
      `ADDR_TH_NEGATE:  v[`CNT_W-1:0] = st.th_negate;
      `ADDR_STATUS: begin
        v[`CNT_W-1:0] = st.count;
        v[8]          = st.empty;
        v[9]          = st.full;
        v[10]         = st.low;
        v[11]         = st.busy;
        v[12]         = st.busy;
        v[13]         = st.ctrl.sleep;
      end
      `ADDR_IRQ_STATUS: v[`IRQ_W-1:0] = st.irq_st;
      `ADDR_IRQ_MASK:   v[`IRQ_W-1:0] = st.irq_mask;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // Storage and error correction

  secded_codec u_codec (
    .enc_data   (din),
    .ecc_en     (s_q.ctrl.ecc_en),
    .inj_single (s_q.ctrl.inject_single),
    .inj_double (s_q.ctrl.inject_double),
    .enc_word   (enc_word),
    .enc_clean  (enc_clean),
    .dec_word   (rd_word),
    .dec_data   (dec_data),
    .dec_single (dec_single),
    .dec_double (dec_double)
  );

  word_store u_store (
    .aclk  (aclk),
    .we    (wr_ok),
    .waddr (s_q.wptr),
    .wword (enc_word),
    .raddr (s_q.rptr),
    .rword (rd_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d     = s_q;
    irq_clr = '0;
    irq_ev  = '0;

    // Bus slave: address and data are latched independently
    if (s_axi_req.awvalid && s_q.rsp.awready) begin
      s_d.awh    = 1'b1;
      s_d.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && s_q.rsp.wready) begin
      s_d.wh    = 1'b1;
      s_d.wdata = s_axi_req.wdata;
      s_d.wstrb = s_axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && s_axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    wr_go = s_q.awh && s_q.wh && !s_q.rsp.bvalid;
    if (wr_go) begin
      s_d.awh        = 1'b0;
      s_d.wh         = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = reg_known(s_q.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      // All writable fields sit in byte lane 0
      if (s_q.wstrb[0]) begin
        case (s_q.awaddr)
          `ADDR_CTRL:       s_d.ctrl = ctrl_t'(s_q.wdata[5:0]);
          `ADDR_TH_SINGLE:  s_d.th_single = s_q.wdata[`CNT_W-1:0];
          `ADDR_TH_ASSERT:  s_d.th_assert = s_q.wdata[`CNT_W-1:0];
          `ADDR_TH_NEGATE:  s_d.th_negate = s_q.wdata[`CNT_W-1:0];
          `ADDR_IRQ_STATUS: irq_clr = s_q.wdata[`IRQ_W-1:0];
          `ADDR_IRQ_MASK:   s_d.irq_mask = s_q.wdata[`IRQ_W-1:0];
          default:          s_d.ctrl = s_q.ctrl;
        endcase
      end
    end
    s_d.rsp.awready = !s_d.awh;
    s_d.rsp.wready  = !s_d.wh;

    if (s_q.rsp.rvalid && s_axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    if (s_axi_req.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rdata  = read_mux(s_axi_req.araddr, s_q);
      s_d.rsp.rresp  = reg_known(s_axi_req.araddr) ? `RESP_OKAY
                                                   : `RESP_SLVERR;
    end
    s_d.rsp.arready = !s_d.rsp.rvalid;

    // Datapath is frozen while asleep or not yet running
    run   = s_q.phase == P_RUN && !s_q.ctrl.sleep &&
            !s_q.ctrl.fifo_reset;
    wr_ok = wr_en && run && s_q.count != `CNT_W'(`DEPTH);
    rd_ok = rd_en && run && s_q.count != '0;
    s_d.overflow  = wr_en && run && s_q.count == `CNT_W'(`DEPTH);
    s_d.underflow = rd_en && run && s_q.count == '0;
    if (wr_ok) begin
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (rd_ok) begin
      s_d.rptr = s_q.rptr + 1'b1;
    end
    s_d.count = s_q.count + `CNT_W'(wr_ok) - `CNT_W'(rd_ok);

    // Word and its error flags leave together
    s_d.dvalid = rd_ok;
    s_d.sbit   = rd_ok && dec_single;
    s_d.dbit   = rd_ok && dec_double;
    if (rd_ok) begin
      s_d.dout = dec_data;
    end

    unique case (s_q.phase)
      P_HOLD: begin
        s_d.phase  = P_SETTLE;
        s_d.settle = `SETTLE_CYCLES - 2'h1;
      end
      P_SETTLE: begin
        if (s_q.settle == 2'h0) begin
          s_d.phase = P_RUN;
        end else begin
          s_d.settle = s_q.settle - 2'h1;
        end
      end
      P_RUN: begin
        s_d.phase = P_RUN;
      end
    endcase

    if (s_q.ctrl.fifo_reset) begin
      s_d.phase  = P_HOLD;
      s_d.wptr   = '0;
      s_d.rptr   = '0;
      s_d.count  = '0;
      s_d.dvalid = 1'b0;
      s_d.sbit   = 1'b0;
      s_d.dbit   = 1'b0;
      // Thresholds are captured only while held in reset
      s_d.th_as  = s_q.ctrl.split_thresh ? s_q.th_assert
                                         : s_q.th_single;
      s_d.th_ng  = s_q.ctrl.split_thresh ? s_q.th_negate
                                         : s_q.th_single;
    end
    s_d.busy  = s_d.phase != P_RUN;
    s_d.full  = s_d.count == `CNT_W'(`DEPTH);
    s_d.empty = s_d.count == '0;

    // Low watermark with hysteresis between the two bounds
    if (s_d.count <= s_d.th_as) begin
      s_d.low = 1'b1;
    end else if (s_d.count > s_d.th_ng) begin
      s_d.low = 1'b0;
    end

    irq_ev[`IRQ_SBIT]  = s_d.sbit;
    irq_ev[`IRQ_DBIT]  = s_d.dbit;
    irq_ev[`IRQ_UNDER] = s_d.underflow;
    irq_ev[`IRQ_OVER]  = s_d.overflow;
    irq_ev[`IRQ_LOW]   = s_d.low && !s_q.low;
    // New events win over a simultaneous clear
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q           <= '0;
      s_q.ctrl      <= ctrl_t'(`CTRL_RST);
      s_q.th_single <= `TH_SINGLE_RST;
      s_q.th_assert <= `TH_ASSERT_RST;
      s_q.th_negate <= `TH_NEGATE_RST;
      s_q.th_as     <= `TH_SINGLE_RST;
      s_q.th_ng     <= `TH_SINGLE_RST;
      s_q.phase     <= P_HOLD;
      s_q.busy      <= 1'b1;
      s_q.empty     <= 1'b1;
      s_q.low       <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign s_axi_rsp   = s_q.rsp;
  assign full        = s_q.full;
  assign overflow    = s_q.overflow;
  assign wr_rst_busy = s_q.busy;
  assign rd_rst_busy = s_q.busy;
  assign dout        = s_q.dout;
  assign dout_valid  = s_q.dvalid;
  assign sbit_err    = s_q.sbit;
  assign dbit_err    = s_q.dbit;
  assign underflow   = s_q.underflow;
  assign empty       = s_q.empty;
  assign prog_empty  = s_q.low;
  assign irq         = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_empty_read;
    rd_en && run && s_q.count == '0;
  endsequence

  sequence s_reset_release;
    s_q.ctrl.fifo_reset ##1 !s_q.ctrl.fifo_reset;
  endsequence

  a_under_flag: assert property (s_empty_read |=>
                                 underflow && !dout_valid)
    else $error("underflow not flagged after empty read");
  a_under_keep: assert property ((s_empty_read and !wr_en) |=>
                                 $stable(s_q.rptr) && s_q.count == '0)
    else $error("empty read disturbed the contents");
  a_low_set: assert property (s_q.count <= s_q.th_as |-> prog_empty)
    else $error("low flag missing at or below threshold");
  a_low_clear: assert property (s_q.count > s_q.th_ng |-> !prog_empty)
    else $error("low flag stuck above negate threshold");
  a_thresh_hold: assert property (!$past(s_q.ctrl.fifo_reset) |->
                                  $stable(s_q.th_as) &&
                                  $stable(s_q.th_ng))
    else $error("threshold changed outside reset");
  a_thresh_one: assert property ($past(s_q.ctrl.fifo_reset) &&
                                 !$past(s_q.ctrl.split_thresh) |->
                                 s_q.th_as == $past(s_q.th_single) &&
                                 s_q.th_ng == $past(s_q.th_single))
    else $error("single threshold not used for both bounds");
  a_thresh_split: assert property ($past(s_q.ctrl.fifo_reset) &&
                                   $past(s_q.ctrl.split_thresh) |->
                                   s_q.th_as == $past(s_q.th_assert))
    else $error("assert threshold not captured");
  a_busy_hold: assert property (s_reset_release |-> wr_rst_busy && rd_rst_busy
                                ##1 wr_rst_busy[*2])
    else $error("reset busy dropped too early");
  a_busy_end: assert property ((!s_q.ctrl.fifo_reset)[*6] |->
                               !rd_rst_busy)
    else $error("reset busy stuck after settle");
  a_sbit_align: assert property (rd_ok && dec_single |=> sbit_err &&
                                 dout_valid && !dbit_err)
    else $error("single error flag not with its word");
  a_dbit_align: assert property (rd_ok && dec_double |=> dbit_err &&
                                 dout_valid)
    else $error("double error flag not with its word");
  a_inject_one: assert property (s_q.ctrl.ecc_en && s_q.ctrl.inject_single &&
                                 !s_q.ctrl.inject_double |->
                                 $countones(enc_word ^ enc_clean) == 1)
    else $error("single injection did not flip one bit");
  a_inject_two: assert property (s_q.ctrl.ecc_en && s_q.ctrl.inject_double |->
                                 $countones(enc_word ^ enc_clean) == 2)
    else $error("double injection did not flip two bits");
  a_sleep_idle: assert property (s_q.ctrl.sleep |=> !dout_valid &&
                                 $stable(s_q.count))
    else $error("datapath moved while asleep");

endmodule : fifo_side

/* test/fifo_user_model.sv */
// User logic on the far side that pushes and pops the FIFO
`timescale 1ns/1ps
`include "fifo_side_params.svh"
module fifo_user_model (
  // Clock
  input  wire logic               aclk,
  // FIFO pins
  output      logic               wr_en,
  output      logic [`DATA_W-1:0] din,
  output      logic               rd_en
);
  initial begin
    wr_en = 1'b0;
    din   = 8'h00;
    rd_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released data shows the inverse so a stale value cannot pass
  task automatic push(input logic [`DATA_W-1:0] d);
    @(posedge aclk);
    wr_en <= 1'b1;
    din   <= d;
    @(posedge aclk);
    wr_en <= 1'b0;
    din   <= ~d;
    #1;
  endtask : push

  task automatic pop();
    @(posedge aclk);
    rd_en <= 1'b1;
    @(posedge aclk);
    rd_en <= 1'b0;
    #1;
  endtask : pop
endmodule : fifo_user_model

/* test/fifo_side_bench.sv */
// Self-checking bench of the FIFO sideband block
`timescale 1ns/1ps
`include "fifo_side_params.svh"
module fifo_side_bench;
  import fifo_side_pkg::*;
  logic              aclk, aresetn;
  axil_req_t         rq;
  axil_rsp_t         rs;
  logic              wr_en, rd_en, full, overflow, wr_rst_busy, rd_rst_busy;
  logic [7:0]        din, dout;
  logic              dout_valid, sbit_err, dbit_err, underflow, empty;
  logic              prog_empty, irq;
  int                failures, tests_run;
  logic [31:0]       seed = 32'h0000_0063;
  logic [7:0]        ra [6] = '{`ADDR_CTRL, `ADDR_TH_SINGLE, `ADDR_TH_ASSERT,
                               `ADDR_TH_NEGATE, `ADDR_IRQ_MASK, `ADDR_STATUS};
  logic [31:0]       rv [6] = '{32'(`CTRL_RST), 32'(`TH_SINGLE_RST),
                               32'(`TH_ASSERT_RST), 32'(`TH_NEGATE_RST),
                               32'h0000_0000, 32'h0000_0500};

  fifo_side dut (.aclk(aclk), .aresetn(aresetn), .s_axi_req(rq),
    .s_axi_rsp(rs), .wr_en(wr_en), .din(din), .full(full),
    .overflow(overflow), .wr_rst_busy(wr_rst_busy), .rd_en(rd_en),
    .dout(dout), .dout_valid(dout_valid), .sbit_err(sbit_err),
    .dbit_err(dbit_err), .underflow(underflow), .empty(empty),
    .prog_empty(prog_empty), .rd_rst_busy(rd_rst_busy), .irq(irq));
  fifo_user_model u_user (.aclk(aclk), .wr_en(wr_en), .din(din),
    .rd_en(rd_en));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected low watermark after the count becomes c
  function automatic logic pe(input logic f, input int c, input int a,
                              input int g);
    if (c <= a) return 1'b1;
    if (c > g) return 1'b0;
    return f;
  endfunction : pe

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge aclk);
    rq.awvalid <= 1'b1;
    rq.awaddr  <= a;
    rq.wvalid  <= 1'b1;
    rq.wdata   <= d;
    rq.wstrb   <= 4'hf;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && rs.awready) begin
        aw = 1'b0;
        rq.awvalid <= 1'b0;
      end
      if (w && rs.wready) begin
        w = 1'b0;
        rq.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!rs.bvalid);
    r = rs.bresp;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    rq.arvalid <= 1'b1;
    rq.araddr  <= a;
    do @(posedge aclk); while (!rs.arready);
    rq.arvalid <= 1'b0;
    do @(posedge aclk); while (!rs.rvalid);
    d = rs.rdata;
    r = rs.rresp;
  endtask : axr

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", r, `RESP_OKAY);
  endtask : wr

  // Soft reset; thresholds are captured while it is held
  task automatic cfg(input logic [31:0] c);
    wr(`ADDR_CTRL, c | 32'h0000_0001);
    wr(`ADDR_CTRL, c);
    #1;
    chk("wr_rst_busy", wr_rst_busy, 1'b1);
    chk("rd_rst_busy", rd_rst_busy, 1'b1);
    while (wr_rst_busy) @(posedge aclk);
  endtask : cfg

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic        f;
    logic [7:0]  q[$];
    int          i, m, a, g;
    failures  = 0;
    tests_run = 0;
    aresetn   = 1'b0;
    rq        = '0;
    rq.bready = 1'b1;
    rq.rready = 1'b1;
    repeat (1) @(posedge aclk);
    #1;
    chk("busy in reset", {wr_rst_busy, rd_rst_busy}, 2'b11);
    chk("flags in reset", {empty, prog_empty}, 2'b11);
    @(posedge aclk);
    aresetn <= 1'b1;
    while (wr_rst_busy) @(posedge aclk);
    for (i = 0; i < 6; i++) begin
      axr(ra[i], v, r);
      chk("reset value", v, rv[i]);
      chk("reset rresp", r, `RESP_OKAY);
    end
    wr(`ADDR_TH_SINGLE, 32'h0000_0003);
    wr(`ADDR_TH_ASSERT, 32'h0000_0002);
    wr(`ADDR_TH_NEGATE, 32'h0000_0005);
    for (m = 0; m < 2; m++) begin
      a = (m == 1) ? 2 : 3;
      g = (m == 1) ? 5 : 3;
      cfg((m == 1) ? 32'h0000_0006 : 32'h0000_0004);
      f = 1'b1;
      for (i = 1; i <= 16; i++) begin
        v = xs();
        q.push_back(v[7:0]);
        u_user.push(v[7:0]);
        f = pe(f, i, a, g);
        chk("prog_empty rising count", prog_empty, f);
      end
      chk("full", full, 1'b1);
      u_user.push(8'h5a);
      chk("overflow", overflow, 1'b1);
      for (i = 15; i >= 0; i--) begin
        u_user.pop();
        chk("dout", {dout_valid, dout}, {1'b1, q.pop_front()});
        f = pe(f, i, a, g);
        chk("prog_empty falling count", prog_empty, f);
      end
    end
    wr(`ADDR_TH_ASSERT, 32'h0000_0000);
    wr(`ADDR_TH_NEGATE, 32'h0000_0000);
    u_user.push(8'h3c);
    chk("threshold held outside reset", prog_empty, 1'b1);
    u_user.pop();
    for (m = 0; m < 2; m++) begin
      wr(`ADDR_CTRL, (m == 1) ? 32'h0000_0014 : 32'h0000_000c);
      v = xs();
      u_user.push(v[7:0]);
      wr(`ADDR_CTRL, 32'h0000_0004);
      u_user.pop();
      chk("sbit_err", {dout_valid, sbit_err}, {1'b1, m == 0});
      chk("dbit_err", {dout_valid, dbit_err}, {1'b1, m == 1});
      if (m == 0) chk("corrected dout", dout, v[7:0]);
    end
    u_user.pop();
    chk("underflow", {underflow, empty}, 2'b11);
    wr(`ADDR_CTRL, 32'h0000_0024);
    u_user.push(8'ha5);
    chk("push in sleep", empty, 1'b1);
    u_user.pop();
    chk("pop in sleep", underflow, 1'b0);
    wr(`ADDR_CTRL, 32'h0000_0004);
    axr(`ADDR_IRQ_STATUS, v, r);
    chk("irq status", v, 32'h0000_001f);
    chk("irq masked", irq, 1'b0);
    wr(`ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq unmasked", irq, 1'b1);
    wr(`ADDR_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq cleared", irq, 1'b0);
    axr(`ADDR_IRQ_STATUS, v, r);
    chk("irq status after clear", v, 32'h0000_001e);
    axw(8'h40, 32'h0000_0001, r);
    chk("unmapped bresp", r, `RESP_SLVERR);
    axr(8'h40, v, r);
    chk("unmapped rresp", r, `RESP_SLVERR);
    chk("unmapped read", v, 32'h0000_0000);
    report_and_stop();
  end
endmodule : fifo_side_bench
